// [inc/dpd_pkg.sv]
package dpd_pkg;
	// Core clock and DRAM cycle timing (EDO, 60 ns class)
	localparam int CLK_PERIOD_NS = 4;
	localparam int T_RCD_NS = 20;
	localparam int T_CAS_NS = 15;
	localparam int T_RP_NS = 40;
	localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAS_CYC = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Panel blanking lengths, counted in dot clock ticks
	localparam int LATCH_TICKS = 2;
	localparam int FRAME_TICKS = 2;

	// Scan data format select
	localparam int MODE_TFT_BIT = 0;
	localparam int MODE_WIDE_BIT = 1;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam int NARROW_BITS = 8;

	localparam int SCAN_W = 12;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;

	typedef enum logic [1:0] {
		P_OFF = 2'b00,
		P_DATA = 2'b01,
		P_LATCH = 2'b10,
		P_FRAME = 2'b11
	} dpd_panel_st_t;

	typedef enum logic [1:0] {
		B_IDLE = 2'b00,
		B_ROW = 2'b01,
		B_COL = 2'b10,
		B_PRE = 2'b11
	} dpd_bank_st_t;

	typedef struct packed {
		logic [SCAN_W-1:0] upper;
		logic [SCAN_W-1:0] lower;
	} dpd_pix_t;

	typedef struct packed {
		logic write;
		logic [1:0] byte_en;
		logic [ADDR_W-1:0] row;
		logic [ADDR_W-1:0] col;
		logic [DATA_W-1:0] wdata;
	} dpd_mem_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic row_strobe_n;
		logic high_col_strobe_n;
		logic low_col_strobe_n;
		logic output_en_n;
		logic write_en_n;
		logic [DATA_W-1:0] dq_out;
		logic dq_oe;
	} dpd_bank_pins_t;
endpackage : dpd_pkg

// [rtl/dpd_fifo.sv]
`timescale 1ns/1ns
module dpd_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} dpd_fifo_state_t;

	dpd_fifo_state_t s_q, s_d;
	logic full, empty;

	always_comb begin
		empty = (s_q.wr_ptr == s_q.rd_ptr);
		full = (s_q.wr_ptr[AW-1:0] == s_q.rd_ptr[AW-1:0]) && (s_q.wr_ptr[AW] != s_q.rd_ptr[AW]);
		in_ready = !full;
		out_valid = !empty;
		out_data = s_q.mem[s_q.rd_ptr[AW-1:0]];
		s_d = s_q;
		if (in_valid && !full) begin
			s_d.mem[s_q.wr_ptr[AW-1:0]] = in_data;
			s_d.wr_ptr = s_q.wr_ptr + (AW+1)'(1);
		end
		if (out_ready && !empty) begin
			s_d.rd_ptr = s_q.rd_ptr + (AW+1)'(1);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : dpd_fifo

// [rtl/dpd_dram_bank.sv]
`timescale 1ns/1ns
module dpd_dram_bank (
	input wire logic clk,
	input wire logic nrst,
	input wire logic req_valid,
	output logic req_ready,
	input dpd_pkg::dpd_mem_req_t req,
	output logic rd_valid,
	output logic [dpd_pkg::DATA_W-1:0] rd_data,
	input wire logic [dpd_pkg::DATA_W-1:0] dq_in,
	output dpd_pkg::dpd_bank_pins_t pins
);
	import dpd_pkg::*;

	typedef struct packed {
		dpd_bank_st_t st;
		logic [3:0] cnt;
		dpd_mem_req_t cur;
		dpd_bank_pins_t pins;
		logic rd_valid;
		logic [DATA_W-1:0] rd_data;
	} dpd_bank_state_t;

	dpd_bank_state_t s_q, s_d;

	// Strobes idle high, data bus released
	function automatic dpd_bank_pins_t idle_pins(input logic [ADDR_W-1:0] addr);
		dpd_bank_pins_t p;
		p = '0;
		p.addr = addr;
		p.row_strobe_n = 1'b1;
		p.high_col_strobe_n = 1'b1;
		p.low_col_strobe_n = 1'b1;
		p.output_en_n = 1'b1;
		p.write_en_n = 1'b1;
		return p;
	endfunction : idle_pins

	always_comb begin
		s_d = s_q;
		s_d.rd_valid = 1'b0;
		req_ready = (s_q.st == B_IDLE);
		unique case (s_q.st)
			B_IDLE: begin
				if (req_valid) begin
					s_d.cur = req;
					s_d.pins.addr = req.row;
					s_d.pins.row_strobe_n = 1'b0; // [R11]
					s_d.cnt = 4'(RCD_CYC - 1);
					s_d.st = B_ROW;
				end
			end
			B_ROW: begin
				if (s_q.cnt != 4'h0) begin
					s_d.cnt = s_q.cnt - 4'h1;
				end else begin
					s_d.pins.addr = s_q.cur.col; // [R9]
					s_d.pins.high_col_strobe_n = !s_q.cur.byte_en[1]; // [R10]
					s_d.pins.low_col_strobe_n = !s_q.cur.byte_en[0]; // [R10]
					s_d.pins.write_en_n = !s_q.cur.write; // [R11]
					s_d.pins.output_en_n = s_q.cur.write; // [R11]
					s_d.pins.dq_out = s_q.cur.wdata;
					s_d.pins.dq_oe = s_q.cur.write; // [R9]
					s_d.cnt = 4'(CAS_CYC - 1);
					s_d.st = B_COL;
				end
			end
			B_COL: begin
				if (s_q.cnt != 4'h0) begin
					s_d.cnt = s_q.cnt - 4'h1;
				end else begin
					if (!s_q.cur.write) begin
						s_d.rd_data = dq_in;
						s_d.rd_valid = 1'b1;
					end
					s_d.pins = idle_pins(s_q.pins.addr); // [R16]
					s_d.cnt = 4'(RP_CYC - 1);
					s_d.st = B_PRE;
				end
			end
			B_PRE: begin
				if (s_q.cnt != 4'h0) begin
					s_d.cnt = s_q.cnt - 4'h1;
				end else begin
					s_d.st = B_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q.st <= B_IDLE;
			s_q.cnt <= 4'h0;
			s_q.cur <= '0;
			s_q.pins <= '{addr: '0, row_strobe_n: 1'b1, high_col_strobe_n: 1'b1, low_col_strobe_n: 1'b1,
				output_en_n: 1'b1, write_en_n: 1'b1, dq_out: '0, dq_oe: 1'b0}; // [R16]
			s_q.rd_valid <= 1'b0;
			s_q.rd_data <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pins = s_q.pins;
	assign rd_valid = s_q.rd_valid;
	assign rd_data = s_q.rd_data;
endmodule : dpd_dram_bank

// [rtl/dpd_panel_top.sv]
`timescale 1ns/1ns
// Function
// R1 - Pulse line latch after each display line; scan data invalid meanwhile.
// R2 - Generate panel shift clock whose edges capture each scan data word.
// R3 - Between frames assert the frame start marker; scan data invalid meanwhile.
// R4 - Drive 12-bit upper scan data, arranged per configured display mode.
// R5 - Drive 12-bit lower scan data, arranged the same way as upper.
// R6 - Panel disable output low when panel disabled, high otherwise.
// R7 - Panel power enable high when supply should reach the panel.
// R8 - Contrast enable high when bias voltage applied, low otherwise.
// R9 - Two DRAM banks, each with own 10-bit address and 16-bit data.
// R10 - Per bank, separate high-byte and low-byte column strobes.
// R11 - Per bank, own active-low row strobe, output enable, write enable.
// R12 - Dot clock times the whole device and runs continuously after reset; design is clocked by CLK, dot clock is sampled to pace panel scan only.
// R13 - Host power request triggers applying power to the panel.
// R14 - Panel control outputs valid only while host control request holds.
// R15 - Two mode bits: bit0 TFT overrides; bit1 picks 16/24-bit DSTN; reset 0.
// R16 - After reset DRAM strobes high and data buses undriven until a cycle.
// R17 - After reset power, contrast and disable outputs low until host requests.
module dpd_panel_top #(
	parameter int WORDS_PER_LINE = 80,
	parameter int LINES_PER_FRAME = 240,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic PIXEL_INPUT_CLOCK,
	input wire logic POWER_REQUEST_IN,
	input wire logic CONTROL_REQUEST_IN,
	input wire logic MODE_WR,
	input wire logic [1:0] MODE_CFG,
	input wire logic PIX_VALID,
	input dpd_pkg::dpd_pix_t PIX_DATA,
	output logic PIX_READY,
	output logic LINE_LATCH_PULSE,
	output logic PANEL_SHIFT_CLOCK,
	output logic FRAME_START_MARKER,
	output logic [dpd_pkg::SCAN_W-1:0] UPPER_SCAN_DATA,
	output logic [dpd_pkg::SCAN_W-1:0] LOWER_SCAN_DATA,
	output logic PANEL_DISABLE_N,
	output logic PANEL_POWER_ENABLE,
	output logic PANEL_CONTRAST_ENABLE,
	input wire logic BANK_A_REQ_VALID,
	output logic BANK_A_REQ_READY,
	input dpd_pkg::dpd_mem_req_t BANK_A_REQ,
	output logic BANK_A_RD_VALID,
	output logic [dpd_pkg::DATA_W-1:0] BANK_A_RD_DATA,
	input wire logic BANK_B_REQ_VALID,
	output logic BANK_B_REQ_READY,
	input dpd_pkg::dpd_mem_req_t BANK_B_REQ,
	output logic BANK_B_RD_VALID,
	output logic [dpd_pkg::DATA_W-1:0] BANK_B_RD_DATA,
	output logic [dpd_pkg::ADDR_W-1:0] BANK_A_ROW_COL_ADDR,
	input wire logic [dpd_pkg::DATA_W-1:0] BANK_A_MEM_DATA_IN,
	output logic [dpd_pkg::DATA_W-1:0] BANK_A_MEM_DATA_OUT,
	output logic BANK_A_MEM_DATA_OE,
	output logic BANK_A_OUTPUT_EN_N,
	output logic BANK_A_ROW_STROBE_N,
	output logic BANK_A_HIGH_COL_STROBE_N,
	output logic BANK_A_LOW_COL_STROBE_N,
	output logic BANK_A_WRITE_EN_N,
	output logic [dpd_pkg::ADDR_W-1:0] BANK_B_ROW_COL_ADDR,
	input wire logic [dpd_pkg::DATA_W-1:0] BANK_B_MEM_DATA_IN,
	output logic [dpd_pkg::DATA_W-1:0] BANK_B_MEM_DATA_OUT,
	output logic BANK_B_MEM_DATA_OE,
	output logic BANK_B_OUTPUT_EN_N,
	output logic BANK_B_ROW_STROBE_N,
	output logic BANK_B_HIGH_COL_STROBE_N,
	output logic BANK_B_LOW_COL_STROBE_N,
	output logic BANK_B_WRITE_EN_N
);
	import dpd_pkg::*;

	localparam int WCW = $clog2(WORDS_PER_LINE + 1);
	localparam int LCW = $clog2(LINES_PER_FRAME + 1);

	typedef struct packed {
		logic [2:0] dot_s;
		logic dot;
		logic [2:0] pwr_s;
		logic pwr;
		logic [2:0] ctl_s;
		logic ctl;
		logic [1:0] mode;
		dpd_panel_st_t st;
		logic [WCW-1:0] word_cnt;
		logic [LCW-1:0] line_cnt;
		logic [3:0] hold_cnt;
		logic shift;
		logic latch;
		logic frame;
		logic [SCAN_W-1:0] upper;
		logic [SCAN_W-1:0] lower;
		logic disable_n;
		logic vdd;
		logic vcon;
	} dpd_top_state_t;

	dpd_top_state_t s_q, s_d;

	logic fifo_valid;
	logic fifo_pop;
	dpd_pix_t fifo_data;
	logic dot_rise;
	logic dot_fall;
	dpd_bank_pins_t pins_a;
	dpd_bank_pins_t pins_b;

	// Lay one half-panel word out for the current mode
	function automatic logic [SCAN_W-1:0] scan_format(input logic [1:0] mode, input logic [SCAN_W-1:0] raw);
		logic [SCAN_W-1:0] f;
		f = '0;
		if (mode[MODE_TFT_BIT]) begin
			f[NARROW_BITS-1:0] = raw[NARROW_BITS-1:0]; // [R15]
		end else if (mode[MODE_WIDE_BIT]) begin
			f = raw; // [R15]
		end else begin
			f[NARROW_BITS-1:0] = raw[NARROW_BITS-1:0]; // [R15]
		end
		return f;
	endfunction : scan_format

	// Three-stage filter: a level counts only once stages two and three agree
	function automatic logic settle(input logic [2:0] s, input logic held);
		return (s[1] == s[2]) ? s[2] : held;
	endfunction : settle

	dpd_fifo #(
		.WIDTH($bits(dpd_pix_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.nrst(NRST),
		.in_valid(PIX_VALID),
		.in_ready(PIX_READY),
		.in_data(PIX_DATA),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	always_comb begin
		s_d = s_q;
		fifo_pop = 1'b0;

		s_d.dot_s = {s_q.dot_s[1:0], PIXEL_INPUT_CLOCK}; // [R12]
		s_d.pwr_s = {s_q.pwr_s[1:0], POWER_REQUEST_IN};
		s_d.ctl_s = {s_q.ctl_s[1:0], CONTROL_REQUEST_IN};
		s_d.dot = settle(s_q.dot_s, s_q.dot);
		s_d.pwr = settle(s_q.pwr_s, s_q.pwr);
		s_d.ctl = settle(s_q.ctl_s, s_q.ctl);
		dot_rise = s_d.dot && !s_q.dot; // [R12]
		dot_fall = !s_d.dot && s_q.dot;

		if (MODE_WR) begin
			s_d.mode = MODE_CFG; // [R15]
		end

		// Power first, contrast one cycle later, both drop in the same cycle
		s_d.vdd = s_q.pwr; // [R7] [R13] [R17]
		s_d.vcon = s_q.pwr && s_q.vdd && s_q.ctl; // [R8] [R17]
		s_d.disable_n = s_q.pwr && s_q.ctl; // [R6] [R17]

		if (dot_fall) begin
			s_d.shift = 1'b0; // [R2]
		end

		if (!s_q.ctl) begin
			// Without a control request the panel lines sit low
			s_d.st = P_OFF; // [R14]
			s_d.shift = 1'b0;
			s_d.latch = 1'b0;
			s_d.frame = 1'b0;
			s_d.upper = '0;
			s_d.lower = '0;
			s_d.word_cnt = '0;
			s_d.line_cnt = '0;
		end else if (dot_rise) begin
			unique case (s_q.st)
				P_OFF: begin
					// Open with a frame marker so the panel starts on line one
					s_d.st = P_FRAME;
					s_d.frame = 1'b1; // [R3]
					s_d.hold_cnt = 4'(FRAME_TICKS - 1);
				end
				P_DATA: begin
					// An empty FIFO stalls the line rather than sending stale data
					if (fifo_valid) begin
						fifo_pop = 1'b1;
						s_d.upper = scan_format(s_q.mode, fifo_data.upper); // [R4]
						s_d.lower = scan_format(s_q.mode, fifo_data.lower); // [R5]
						s_d.shift = 1'b1; // [R2]
						if (s_q.word_cnt == WCW'(WORDS_PER_LINE - 1)) begin
							s_d.word_cnt = '0;
							s_d.st = P_LATCH;
						end else begin
							s_d.word_cnt = s_q.word_cnt + WCW'(1);
						end
					end
				end
				P_LATCH: begin
					s_d.latch = 1'b1; // [R1]
					s_d.upper = '0; // [R1]
					s_d.lower = '0;
					if (!s_q.latch) begin
						s_d.hold_cnt = 4'(LATCH_TICKS - 1);
					end else if (s_q.hold_cnt != 4'h0) begin
						s_d.hold_cnt = s_q.hold_cnt - 4'h1;
					end else begin
						s_d.latch = 1'b0;
						if (s_q.line_cnt == LCW'(LINES_PER_FRAME - 1)) begin
							s_d.line_cnt = '0;
							s_d.st = P_FRAME;
							s_d.frame = 1'b1; // [R3]
							s_d.hold_cnt = 4'(FRAME_TICKS - 1);
						end else begin
							s_d.line_cnt = s_q.line_cnt + LCW'(1);
							s_d.st = P_DATA;
						end
					end
				end
				P_FRAME: begin
					s_d.upper = '0; // [R3]
					s_d.lower = '0;
					if (s_q.hold_cnt != 4'h0) begin
						s_d.hold_cnt = s_q.hold_cnt - 4'h1;
					end else begin
						s_d.frame = 1'b0;
						s_d.st = P_DATA;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			s_q <= '0;
			s_q.mode <= MODE_RESET; // [R15]
			s_q.st <= P_OFF;
		end else begin
			s_q <= s_d;
		end
	end

	assign LINE_LATCH_PULSE = s_q.latch;
	assign PANEL_SHIFT_CLOCK = s_q.shift;
	assign FRAME_START_MARKER = s_q.frame;
	assign UPPER_SCAN_DATA = s_q.upper;
	assign LOWER_SCAN_DATA = s_q.lower;
	assign PANEL_DISABLE_N = s_q.disable_n;
	assign PANEL_POWER_ENABLE = s_q.vdd;
	assign PANEL_CONTRAST_ENABLE = s_q.vcon;

	// Each bank runs its own sequencer so both can overlap [R9] [R11]
	dpd_dram_bank u_bank_a (
		.clk(CLK),
		.nrst(NRST),
		.req_valid(BANK_A_REQ_VALID),
		.req_ready(BANK_A_REQ_READY),
		.req(BANK_A_REQ),
		.rd_valid(BANK_A_RD_VALID),
		.rd_data(BANK_A_RD_DATA),
		.dq_in(BANK_A_MEM_DATA_IN),
		.pins(pins_a)
	);

	dpd_dram_bank u_bank_b (
		.clk(CLK),
		.nrst(NRST),
		.req_valid(BANK_B_REQ_VALID),
		.req_ready(BANK_B_REQ_READY),
		.req(BANK_B_REQ),
		.rd_valid(BANK_B_RD_VALID),
		.rd_data(BANK_B_RD_DATA),
		.dq_in(BANK_B_MEM_DATA_IN),
		.pins(pins_b)
	);

	assign BANK_A_ROW_COL_ADDR = pins_a.addr;
	assign BANK_A_MEM_DATA_OUT = pins_a.dq_out;
	assign BANK_A_MEM_DATA_OE = pins_a.dq_oe;
	assign BANK_A_OUTPUT_EN_N = pins_a.output_en_n;
	assign BANK_A_ROW_STROBE_N = pins_a.row_strobe_n;
	assign BANK_A_HIGH_COL_STROBE_N = pins_a.high_col_strobe_n;
	assign BANK_A_LOW_COL_STROBE_N = pins_a.low_col_strobe_n;
	assign BANK_A_WRITE_EN_N = pins_a.write_en_n;
	assign BANK_B_ROW_COL_ADDR = pins_b.addr;
	assign BANK_B_MEM_DATA_OUT = pins_b.dq_out;
	assign BANK_B_MEM_DATA_OE = pins_b.dq_oe;
	assign BANK_B_OUTPUT_EN_N = pins_b.output_en_n;
	assign BANK_B_ROW_STROBE_N = pins_b.row_strobe_n;
	assign BANK_B_HIGH_COL_STROBE_N = pins_b.high_col_strobe_n;
	assign BANK_B_LOW_COL_STROBE_N = pins_b.low_col_strobe_n;
	assign BANK_B_WRITE_EN_N = pins_b.write_en_n;
endmodule : dpd_panel_top

// [dv/dpd_chk.sv]
`timescale 1ns/1ns
module dpd_chk (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic LINE_LATCH_PULSE,
	input wire logic PANEL_SHIFT_CLOCK,
	input wire logic FRAME_START_MARKER,
	input wire logic [dpd_pkg::SCAN_W-1:0] UPPER_SCAN_DATA,
	input wire logic [dpd_pkg::SCAN_W-1:0] LOWER_SCAN_DATA,
	input wire logic PANEL_POWER_ENABLE,
	input wire logic PANEL_CONTRAST_ENABLE,
	input wire logic BANK_A_REQ_VALID,
	input wire logic BANK_A_REQ_READY,
	input wire dpd_pkg::dpd_mem_req_t BANK_A_REQ,
	input wire logic [dpd_pkg::ADDR_W-1:0] BANK_A_ROW_COL_ADDR,
	input wire logic BANK_A_MEM_DATA_OE,
	input wire logic BANK_A_OUTPUT_EN_N,
	input wire logic BANK_A_ROW_STROBE_N,
	input wire logic BANK_A_HIGH_COL_STROBE_N,
	input wire logic BANK_A_LOW_COL_STROBE_N,
	input wire logic BANK_A_WRITE_EN_N,
	input wire logic BANK_B_REQ_VALID,
	input wire logic BANK_B_REQ_READY,
	input wire logic BANK_B_ROW_STROBE_N
);
	import dpd_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	wire take_a = BANK_A_REQ_VALID && BANK_A_REQ_READY;
	latch_blank_a: assert property (LINE_LATCH_PULSE |-> !(UPPER_SCAN_DATA | LOWER_SCAN_DATA))
		else $error("scan data during latch");
	frame_blank_a: assert property (FRAME_START_MARKER |-> !(UPPER_SCAN_DATA | LOWER_SCAN_DATA))
		else $error("scan data during frame marker");
	shift_outside_a: assert property ($rose(PANEL_SHIFT_CLOCK) |-> !LINE_LATCH_PULSE && !FRAME_START_MARKER)
		else $error("shift clock during blanking");
	contrast_order_a: assert property ($rose(PANEL_CONTRAST_ENABLE) |-> $past(PANEL_POWER_ENABLE))
		else $error("contrast before power");
	row_take_a: assert property (take_a |=> !BANK_A_ROW_STROBE_N && BANK_A_ROW_COL_ADDR == $past(BANK_A_REQ.row))
		else $error("row strobe not on take");
	col_addr_a: assert property (take_a |-> ##6 BANK_A_ROW_COL_ADDR == $past(BANK_A_REQ.col, 6))
		else $error("column address late");
	col_byte_a: assert property (take_a |-> ##6 BANK_A_HIGH_COL_STROBE_N != $past(BANK_A_REQ.byte_en[1], 6))
		else $error("high byte strobe wrong");
	cas_in_ras_a: assert property (!(BANK_A_HIGH_COL_STROBE_N && BANK_A_LOW_COL_STROBE_N) |-> !BANK_A_ROW_STROBE_N)
		else $error("column strobe outside row");
	we_excl_a: assert property (!BANK_A_WRITE_EN_N |-> BANK_A_OUTPUT_EN_N && BANK_A_MEM_DATA_OE)
		else $error("write without data drive");
	idle_quiet_a: assert property (BANK_A_REQ_READY |-> BANK_A_ROW_STROBE_N && !BANK_A_MEM_DATA_OE)
		else $error("idle bank not quiet");
	row_take_b_a: assert property (BANK_B_REQ_VALID && BANK_B_REQ_READY |=> !BANK_B_ROW_STROBE_N)
		else $error("bank b row strobe missing");
	latch_c: cover property ($rose(LINE_LATCH_PULSE));
	frame_c: cover property ($rose(FRAME_START_MARKER));
	low_write_c: cover property (take_a && BANK_A_REQ.write && BANK_A_REQ.byte_en == 2'b01);
endmodule : dpd_chk
bind dpd_panel_top dpd_chk dpd_chk_inst (.*);

// [dv/dpd_dram_model.sv]
`timescale 1ns/1ns
module dpd_dram_model (
	input wire logic clk,
	input wire logic [dpd_pkg::ADDR_W-1:0] addr,
	input wire logic ras_n,
	input wire logic hcas_n,
	input wire logic lcas_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [dpd_pkg::DATA_W-1:0] dq_in,
	input wire logic dq_oe,
	output logic [dpd_pkg::DATA_W-1:0] dq_out = 16'h0000
);
	import dpd_pkg::*;
	logic [DATA_W-1:0] mem [int];
	logic [ADDR_W-1:0] row_q = '0;
	logic ras_q = 1'b1;
	logic [DATA_W-1:0] w;
	int k;
	always @(posedge clk) begin
		ras_q <= ras_n;
		if (!ras_n && ras_q) row_q <= addr;
		k = {row_q, addr};
		w = mem.exists(k) ? mem[k] : 16'h0000;
		if (!ras_n && !we_n && dq_oe) begin
			if (!hcas_n) w[15:8] = dq_in[15:8];
			if (!lcas_n) w[7:0] = dq_in[7:0];
			mem[k] = w;
		end
		// Released lanes toggle so a stale sample never looks valid
		if (!ras_n && !oe_n)
			dq_out <= {hcas_n ? ~dq_out[15:8] : w[15:8], lcas_n ? ~dq_out[7:0] : w[7:0]};
		else
			dq_out <= ~dq_out;
	end
endmodule : dpd_dram_model

// [dv/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
	import dpd_pkg::*;
	localparam int WPL = 4;
	localparam int LPF = 3;
	logic clk = 0, nrst = 0, dot = 0, pwr = 0, ctl = 0, mwr = 0, pv = 0, sc_q = 0, ll_q = 0, fm_q = 0;
	logic [1:0] mode = 0, rv = 0;
	dpd_pix_t pd = '0;
	dpd_mem_req_t rq [2] = '{default: '0};
	wire prdy, ll, sc, fm, dis_n, pen, cen;
	wire [11:0] ud, ld;
	wire [1:0] rdy, rdv, ras_n, hc_n, lc_n, oe_n, we_n, doe;
	wire [15:0] rdd [2], dout [2], din [2];
	wire [9:0] ma [2];
	int n_errors = 0, n_checks = 0, cyc = 0, wc = 0, lc = 0, i, m, n;
	logic [23:0] exp_q [$];
	logic [23:0] px, pm;
	logic [15:0] ref_m [int];
	logic [31:0] a;

	dpd_panel_top #(.WORDS_PER_LINE(WPL), .LINES_PER_FRAME(LPF), .FIFO_DEPTH(16)) dpd_panel_top_inst (
		.CLK(clk), .NRST(nrst), .PIXEL_INPUT_CLOCK(dot), .POWER_REQUEST_IN(pwr), .CONTROL_REQUEST_IN(ctl),
		.MODE_WR(mwr), .MODE_CFG(mode), .PIX_VALID(pv), .PIX_DATA(pd), .PIX_READY(prdy),
		.LINE_LATCH_PULSE(ll), .PANEL_SHIFT_CLOCK(sc), .FRAME_START_MARKER(fm), .UPPER_SCAN_DATA(ud),
		.LOWER_SCAN_DATA(ld), .PANEL_DISABLE_N(dis_n), .PANEL_POWER_ENABLE(pen), .PANEL_CONTRAST_ENABLE(cen),
		.BANK_A_REQ_VALID(rv[0]), .BANK_A_REQ_READY(rdy[0]), .BANK_A_REQ(rq[0]), .BANK_A_RD_VALID(rdv[0]),
		.BANK_A_RD_DATA(rdd[0]), .BANK_B_REQ_VALID(rv[1]), .BANK_B_REQ_READY(rdy[1]), .BANK_B_REQ(rq[1]),
		.BANK_B_RD_VALID(rdv[1]), .BANK_B_RD_DATA(rdd[1]), .BANK_A_ROW_COL_ADDR(ma[0]),
		.BANK_A_MEM_DATA_IN(din[0]), .BANK_A_MEM_DATA_OUT(dout[0]), .BANK_A_MEM_DATA_OE(doe[0]),
		.BANK_A_OUTPUT_EN_N(oe_n[0]), .BANK_A_ROW_STROBE_N(ras_n[0]), .BANK_A_HIGH_COL_STROBE_N(hc_n[0]),
		.BANK_A_LOW_COL_STROBE_N(lc_n[0]), .BANK_A_WRITE_EN_N(we_n[0]), .BANK_B_ROW_COL_ADDR(ma[1]),
		.BANK_B_MEM_DATA_IN(din[1]), .BANK_B_MEM_DATA_OUT(dout[1]), .BANK_B_MEM_DATA_OE(doe[1]),
		.BANK_B_OUTPUT_EN_N(oe_n[1]), .BANK_B_ROW_STROBE_N(ras_n[1]), .BANK_B_HIGH_COL_STROBE_N(hc_n[1]),
		.BANK_B_LOW_COL_STROBE_N(lc_n[1]), .BANK_B_WRITE_EN_N(we_n[1])
	);
	for (genvar g = 0; g < 2; g++) begin : g_mem
		dpd_dram_model dpd_dram_model_inst (.clk(clk), .addr(ma[g]), .ras_n(ras_n[g]), .hcas_n(hc_n[g]),
			.lcas_n(lc_n[g]), .oe_n(oe_n[g]), .we_n(we_n[g]), .dq_in(dout[g]), .dq_oe(doe[g]), .dq_out(din[g]));
	end

	always #2 clk = ~clk;
	// Dot clock runs free from an unrelated phase
	initial begin
		#7;
		forever #32 dot = ~dot;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic report_and_stop();
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	// Narrow modes carry 8 bits on the low lanes; bit0 overrides bit1
	function automatic logic [11:0] fmt(input logic [11:0] v);
		return (mode[0] || !mode[1]) ? {4'h0, v[7:0]} : v;
	endfunction : fmt

	task automatic mem_op(input int b, input logic w, input logic [1:0] be, input logic [31:0] ad, input logic [31:0] d);
		int k, t;
		logic [15:0] e;
		// Let an edge pass so a lowered valid from the last call is seen low
		@(posedge clk) #1;
		k = b * 32'h0010_0000 + int'(ad[19:0]);
		rq[b] = '{w, be, ad[19:10], ad[9:0], d[15:0]};
		rv[b] = 1;
		for (t = 0; t < 40 && rdy[b] !== 1'b1; t++) @(posedge clk) #1;
		@(posedge clk) #1;
		rv[b] = 0;
		e = ref_m.exists(k) ? ref_m[k] : 16'h0000;
		if (w) begin
			if (be[1]) e[15:8] = d[15:8];
			if (be[0]) e[7:0] = d[7:0];
			ref_m[k] = e;
		end else begin
			for (t = 0; t < 40 && rdv[b] !== 1'b1; t++) @(posedge clk) #1;
			chk("read_valid", rdv[b], 1);
			chk("read_data", rdd[b], e);
		end
	endtask : mem_op

	// Sample panel lines mid-cycle, where they are settled
	always @(negedge clk) begin
		sc_q <= sc;
		ll_q <= ll;
		fm_q <= fm;
		cyc++;
		if (cyc > 40000) begin
			n_errors++;
			report_and_stop();
		end
		if (sc && !sc_q) begin
			if (exp_q.size() == 0)
				chk("extra_word", 1, 0);
			else begin
				pm = exp_q.pop_front();
				chk("upper_scan", ud, fmt(pm[23:12]));
				chk("lower_scan", ld, fmt(pm[11:0]));
				wc++;
			end
		end
		if (ll && !ll_q) begin
			chk("line_words", wc, WPL);
			wc = 0;
			lc++;
		end
		if (fm && !fm_q) begin
			chk("frame_lines", lc == 0 || lc == LPF, 1);
			lc = 0;
		end
	end

	initial begin
		void'($urandom(32'h0000_17fd));
		repeat (8) @(posedge clk);
		#1 nrst = 1;
		@(posedge clk) #1;
		chk("reset_strobes", {ras_n, hc_n, lc_n, oe_n, we_n, doe}, 12'hffc);
		chk("reset_panel", {pen, cen, dis_n, sc, ll, fm, prdy, rdy}, 8'h07);
		pwr = 1;
		repeat (10) @(posedge clk) #1;
		chk("power_only", {pen, cen, dis_n}, 3'b100);
		for (m = 0; m < 4; m++) begin
			mode = m[1:0];
			mwr = (m > 0);
			@(posedge clk) #1 mwr = 0;
			// Fill with the panel off so nothing drains, then one more is refused
			for (n = 0; n < 20; n++) begin
				px = 24'($urandom);
				if (prdy !== 1'b1) break;
				pd = px;
				pv = 1;
				exp_q.push_back(px);
				@(posedge clk) #1;
			end
			pv = 0;
			chk("fifo_depth", n, 16);
			ctl = 1;
			repeat (10) @(posedge clk) #1;
			chk("panel_on", {pen, cen, dis_n}, 3'b111);
			for (n = 0; n < 3000 && exp_q.size() > 0; n++) @(posedge clk) #1;
			chk("drained", exp_q.size(), 0);
			repeat (80) @(posedge clk) #1;
			ctl = 0;
			repeat (10) @(posedge clk) #1;
			chk("panel_off", {sc, ll, fm, ud, ld, dis_n, cen}, 0);
			wc = 0;
			lc = 0;
		end
		for (i = 0; i < 2; i++) begin
			a = $urandom;
			mem_op(i, 1, 2'b11, a, $urandom);
			// Request while busy must be ignored
			rq[i].wdata = 16'h0000;
			@(posedge clk) #1 rv[i] = 1;
			repeat (3) @(posedge clk) #1;
			rv[i] = 0;
			mem_op(i, 1, 2'b01, a, $urandom);
			mem_op(i, 1, 2'b10, a ^ 1, $urandom);
			mem_op(i, 1, 2'b00, a, $urandom);
			mem_op(i, 0, 2'b11, a, 0);
			mem_op(i, 0, 2'b11, a ^ 1, 0);
		end
		// Both banks at once to show they run independently
		fork
			mem_op(0, 0, 2'b11, a, 0);
			mem_op(1, 0, 2'b11, a, 0);
		join
		pwr = 0;
		repeat (10) @(posedge clk) #1;
		chk("power_off", {pen, cen, dis_n}, 0);
		report_and_stop();
	end
endmodule : tb_top
